//--- rtl/ssw_pkg.sv
package ssw_pkg;
  // word geometry
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned FIELD_W = 6;
  localparam int unsigned SLOT_N = 64;
  localparam int unsigned PSU_N = 6;
  localparam int unsigned BYTE_N = 2;
  // bit positions inside the status word
  localparam int unsigned ACTIVE_BIT = 15;
  localparam int unsigned SIM_BIT = 14;
  localparam int unsigned FAULT_BIT = 13;
  localparam int unsigned MODF_BIT = 12;
  localparam int unsigned CODE_LSB = 8;
  localparam int unsigned MULTI_BIT = 7;
  localparam int unsigned PARAM_BIT = 6;
  localparam int unsigned FIELD_LSB = 0;
  // byte order on the cyclic input data, high byte first
  localparam logic IDX_HIGH = 1'h0;
  localparam logic IDX_LOW = 1'h1;
  // reset values
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // error codes
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_IOC_RAM = 4'h1;
  localparam logic [3:0] CODE_IOC_REG = 4'h2;
  localparam logic [3:0] CODE_IOC_FLASH = 4'h3;
  localparam logic [3:0] CODE_IOC_INT = 4'h4;
  localparam logic [3:0] CODE_IOC_CMD = 4'h5;
  localparam logic [3:0] CODE_MODULE = 4'h6;
  localparam logic [3:0] CODE_PSU = 4'h7;
  localparam logic [3:0] CODE_MP_RAM = 4'h8;
  localparam logic [3:0] CODE_MP_FLASH = 4'h9;
  localparam logic [3:0] CODE_MP_WDOG = 4'hA;
  localparam logic [3:0] CODE_RED_ARITH = 4'hB;
  localparam logic [3:0] CODE_RED_PARTNER = 4'hC;
  localparam logic [3:0] CODE_RED_LINK = 4'hD;
  localparam logic [3:0] CODE_RED_PARAM = 4'hE;
  localparam logic [3:0] CODE_RESERVED = 4'hF;
  // saturation value of the six-bit field
  localparam logic [5:0] FIELD_MAX = 6'h3F;
endpackage : ssw_pkg

//--- rtl/ssw_byte_mem.sv
`timescale 1ns/1ps
`default_nettype none
// two-byte image of the status word, registered read port
module ssw_byte_mem (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // write side, whole word each cycle
  input wire logic [15:0] wr_word_i,
  // read side
  input wire logic rd_en_i,
  input wire logic rd_idx_i,
  output logic [7:0] rd_data_o
);
  typedef struct packed {
    logic [ssw_pkg::BYTE_N-1:0][7:0] mem;
    logic [7:0] rd_data;
  } ssw_mem_state_t;

  ssw_mem_state_t st;
  ssw_mem_state_t next_st;

  // read sees the image before this edge's write, so a byte matches status_word_o of the request cycle
  always_comb begin
    next_st = st;
    if (rd_en_i) begin
      next_st.rd_data = st.mem[rd_idx_i];
    end
    next_st.mem[ssw_pkg::IDX_HIGH] = wr_word_i[15:8];
    next_st.mem[ssw_pkg::IDX_LOW] = wr_word_i[7:0];
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_o = st.rd_data;
endmodule : ssw_byte_mem
`default_nettype wire

//--- rtl/ssw_status_word.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - word sent as two bytes, high first
// - bit 14 set while any module simulated
// - top-priority error code in bits 11..8
// - power supply fault uses code 7
// - single module fault: slot number in low bits
// - multiple faults: active error count there
// - only supply faults: per-supply fault bitmap
// - codes 0..6: none, controller errors, module
// - codes 8, 9, A: main processor errors
// - codes B..E redundancy; F never reported
module ssw_status_word (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // station state
  input wire logic unit_active_i,
  input wire logic [63:0] slot_sim_i,
  input wire logic param_busy_i,
  // fault sources
  input wire logic [15:0] gen_fault_i,
  input wire logic [63:0] slot_fault_i,
  input wire logic [5:0] psu_fault_i,
  // cyclic input data byte port
  input wire logic byte_req_i,
  input wire logic byte_idx_i,
  output logic byte_valid_o,
  output logic [7:0] byte_data_o,
  // whole word
  output logic [15:0] status_word_o
);
  typedef struct packed {
    logic [15:0] word;
    logic valid;
  } ssw_state_t;

  ssw_state_t st;
  ssw_state_t next_st;

  // what the low six bits mean this cycle
  typedef enum logic [1:0] {
    FSRC_NONE,
    FSRC_SLOT,
    FSRC_COUNT,
    FSRC_MAP
  } ssw_field_src_t;

  // fault summary signals
  logic [3:0] code;
  logic [5:0] field;
  logic [5:0] cnt_sat;
  logic [5:0] first_slot;
  logic [15:0] gen_valid;
  logic [15:0] code_hit;
  logic [15:0] word_now;
  logic mod_any;
  logic psu_any;
  logic gen_any;
  logic psu_only;
  logic multi;
  logic any_fault;
  ssw_field_src_t field_src;

  // counters and the first-slot search
  logic [7:0] err_cnt;
  logic [6:0] slot_cnt;
  logic [2:0] psu_cnt;
  logic [4:0] gen_cnt;
  logic [64:0] slot_seen;
  logic [63:0] slot_first;

  // per-code qualification; 0, 6, 7 and F never come from a general source
  for (genvar i = 0; i < 16; i++) begin : g_code
    if (i == int'(ssw_pkg::CODE_NONE) || i == int'(ssw_pkg::CODE_MODULE) ||
        i == int'(ssw_pkg::CODE_PSU) || i == int'(ssw_pkg::CODE_RESERVED)) begin : g_unused
      assign gen_valid[i] = 1'h0;
    end else begin : g_used
      assign gen_valid[i] = gen_fault_i[i];
    end
  end

  // one presence flag per code; module and supply faults fill their own places
  always_comb begin
    code_hit = gen_valid;
    code_hit[ssw_pkg::CODE_MODULE] = mod_any;
    code_hit[ssw_pkg::CODE_PSU] = psu_any;
  end

  // lowest code number wins, so a supply fault hides behind codes 1 to 6
  always_comb begin
    code = ssw_pkg::CODE_NONE;
    for (int i = 15; i >= 1; i--) begin
      if (code_hit[i]) begin
        code = 4'(i);
      end
    end
  end

  // ripple of faults below each slot; the first faulty one has none below it
  assign slot_seen[0] = 1'h0;
  for (genvar i = 0; i < ssw_pkg::SLOT_N; i++) begin : g_slot
    assign slot_seen[i + 1] = slot_seen[i] | slot_fault_i[i];
    assign slot_first[i] = slot_fault_i[i] & ~slot_seen[i];
  end

  // one-hot first slot to slot number; at most one bit is set, so OR is enough
  always_comb begin
    first_slot = '0;
    for (int i = 0; i < 64; i++) begin
      if (slot_first[i]) begin
        first_slot = first_slot | 6'(i);
      end
    end
  end

  // faulty slots; seven bits hold all 64
  always_comb begin
    slot_cnt = '0;
    for (int i = 0; i < 64; i++) begin
      slot_cnt = slot_cnt + 7'(slot_fault_i[i]);
    end
  end

  // faulty supplies
  always_comb begin
    psu_cnt = '0;
    for (int i = 0; i < ssw_pkg::PSU_N; i++) begin
      psu_cnt = psu_cnt + 3'(psu_fault_i[i]);
    end
  end

  // active general sources, at most twelve
  always_comb begin
    gen_cnt = '0;
    for (int i = 0; i < 16; i++) begin
      gen_cnt = gen_cnt + 5'(gen_valid[i]);
    end
  end

  // narrow partial counts keep the adders small; the sum of 82 fits eight bits
  assign err_cnt = 8'(slot_cnt) + 8'(psu_cnt) + 8'(gen_cnt);

  // fault summaries
  assign mod_any = |slot_fault_i;
  assign psu_any = |psu_fault_i;
  assign gen_any = |gen_valid;
  assign any_fault = mod_any | psu_any | gen_any;
  assign psu_only = psu_any & ~mod_any & ~gen_any;
  // several supply faults alone still read as the bitmap case
  assign multi = (err_cnt > 8'h01) & ~psu_only;

  // choose the meaning of the low field, bitmap first
  always_comb begin
    field_src = FSRC_NONE;
    if (psu_only) begin
      field_src = FSRC_MAP;
    end else if (multi) begin
      field_src = FSRC_COUNT;
    end else if (mod_any) begin
      field_src = FSRC_SLOT;
    end
  end

  // the count saturates since the field has six bits only
  assign cnt_sat = (err_cnt > {2'h0, ssw_pkg::FIELD_MAX}) ? ssw_pkg::FIELD_MAX : err_cnt[5:0];

  // low field selection; a single general fault leaves it at zero
  always_comb begin
    unique case (field_src)
      FSRC_MAP: field = psu_fault_i;
      FSRC_COUNT: field = cnt_sat;
      FSRC_SLOT: field = first_slot;
      FSRC_NONE: field = '0;
    endcase
  end

  // assemble the word from the summaries
  always_comb begin
    word_now = ssw_pkg::WORD_RST;
    word_now[ssw_pkg::ACTIVE_BIT] = unit_active_i;
    word_now[ssw_pkg::SIM_BIT] = |slot_sim_i;
    word_now[ssw_pkg::FAULT_BIT] = any_fault;
    word_now[ssw_pkg::MODF_BIT] = (code == ssw_pkg::CODE_MODULE);
    word_now[ssw_pkg::CODE_LSB +: ssw_pkg::CODE_W] = code;
    word_now[ssw_pkg::MULTI_BIT] = multi;
    word_now[ssw_pkg::PARAM_BIT] = param_busy_i;
    word_now[ssw_pkg::FIELD_LSB +: ssw_pkg::FIELD_W] = field;
  end

  // the byte answer follows each request by one cycle
  always_comb begin
    next_st = st;
    next_st.word = word_now;
    next_st.valid = byte_req_i;
  end

  // one register for word and answer flag, synchronous reset
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st <= '{word: ssw_pkg::WORD_RST, valid: 1'h0};
    end else begin
      st <= next_st;
    end
  end

  // byte image follows the word register, index 0 is the high byte
  ssw_byte_mem u_mem (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_word_i(next_st.word),
    .rd_en_i(byte_req_i),
    .rd_idx_i(byte_idx_i),
    .rd_data_o(byte_data_o)
  );

  // outputs straight from the registers
  assign byte_valid_o = st.valid;
  assign status_word_o = st.word;
endmodule : ssw_status_word
`default_nettype wire

//--- dv/ssw_props.sv
`timescale 1ns/1ps
`default_nettype none
// watches the word and the byte port from outside
module ssw_props (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // station inputs
  input wire logic unit_active_i,
  input wire logic [63:0] slot_sim_i,
  input wire logic param_busy_i,
  input wire logic [15:0] gen_fault_i,
  input wire logic [63:0] slot_fault_i,
  input wire logic [5:0] psu_fault_i,
  input wire logic byte_req_i,
  input wire logic byte_idx_i,
  // design outputs
  input wire logic byte_valid_o,
  input wire logic [7:0] byte_data_o,
  input wire logic [15:0] status_word_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // antecedents start only after release, so $past never sees reset state
  sequence live_s; !sys_rst_i; endsequence
  sequence take_s; !sys_rst_i && byte_req_i; endsequence
  sequence psu_only_s; live_s ##0 (psu_fault_i != 6'h00 && (gen_fault_i & 16'h7F3E) == 16'h0000
    && slot_fault_i == 64'h0); endsequence
  state_bits_a: assert property (live_s |=> status_word_o[15:14] == {$past(unit_active_i), |$past(slot_sim_i)})
    else $error("state bits");
  param_bit_a: assert property (live_s |=> status_word_o[6] == $past(param_busy_i))
    else $error("param bit");
  fault_bits_a: assert property (status_word_o[13:12] == {status_word_o[11:8] != 4'h0, status_word_o[11:8] == 4'h6})
    else $error("fault bits");
  no_reserved_a: assert property (status_word_o[11:8] != 4'hF)
    else $error("reserved code");
  psu_map_a: assert property (psu_only_s |=> {status_word_o[11:7], status_word_o[5:0]} == {5'hE, $past(psu_fault_i)})
    else $error("supply map");
  byte_valid_a: assert property (live_s |=> byte_valid_o == $past(byte_req_i))
    else $error("byte valid");
  byte_data_a: assert property (take_s |=> byte_data_o == ($past(byte_idx_i) ? $past(status_word_o[7:0])
    : $past(status_word_o[15:8])))
    else $error("byte data");
  data_hold_a: assert property (live_s ##0 !byte_req_i |=> $stable(byte_data_o))
    else $error("byte hold");
endmodule : ssw_props
bind ssw_status_word ssw_props ssw_props_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .unit_active_i(unit_active_i), .slot_sim_i(slot_sim_i), .param_busy_i(param_busy_i), .gen_fault_i(gen_fault_i),
  .slot_fault_i(slot_fault_i), .psu_fault_i(psu_fault_i), .byte_req_i(byte_req_i), .byte_idx_i(byte_idx_i),
  .byte_valid_o(byte_valid_o), .byte_data_o(byte_data_o), .status_word_o(status_word_o));
`default_nettype wire

//--- dv/ssw_dp_master.sv
`timescale 1ns/1ps
`default_nettype none
// bus master side: fetches the word high byte then low byte
module ssw_dp_master (
  // clock and trigger
  input wire logic clk_i,
  input wire logic go_i,
  // byte port
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  output logic req_o = 1'b0,
  output logic idx_o = 1'b0,
  output logic [15:0] word_o = 16'h0000
);
  logic [1:0] st = 2'h0;
  logic g;
  // go taken at the edge, drives moved 1 ns later to stay off the edge;
  // the byte seen then answers the index still standing on idx_o
  always @(posedge clk_i) begin
    g = go_i;
    #1;
    if (valid_i) begin
      if (idx_o) begin
        word_o[7:0] = data_i;
      end else begin
        word_o[15:8] = data_i;
      end
    end
    if (st != 2'h0 || g) begin
      st = st + 2'h1;
    end
    req_o = st == 2'h1 || st == 2'h2;
    idx_o = st == 2'h2;
  end
endmodule : ssw_dp_master
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic act = 1'b1, par = 1'b0, go = 1'b0, req, idx, vld;
  logic [63:0] sim = 64'h0, slot = 64'h0;
  logic [15:0] gen = 16'h0000, word, got;
  logic [5:0] psu = 6'h00;
  logic [7:0] dat;
  int miscompares = 0;
  int tests_run = 0;
  ssw_status_word ssw_status_word_inst (.sys_clk_i(clk), .sys_rst_i(rst), .unit_active_i(act), .slot_sim_i(sim),
    .param_busy_i(par), .gen_fault_i(gen), .slot_fault_i(slot), .psu_fault_i(psu), .byte_req_i(req),
    .byte_idx_i(idx), .byte_valid_o(vld), .byte_data_o(dat), .status_word_o(word));
  ssw_dp_master ssw_dp_master_inst (.clk_i(clk), .go_i(go), .valid_i(vld), .data_i(dat), .req_o(req),
    .idx_o(idx), .word_o(got));
  // free running clock
  initial forever #4 clk = ~clk;
  task check(string name, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // inputs held steady across the fetch so both bytes are coherent
  task apply(logic [15:0] g, logic [63:0] s, logic [5:0] p, logic [15:0] e);
    @(posedge clk); #1;
    gen = g;
    slot = s;
    psu = p;
    go = 1'b1;
    @(posedge clk); #1;
    go = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check("word", word, e);
    check("bytes", got, e);
  endtask : apply
  task t_state;
    sim = 64'h1 << 63;
    par = 1'b1;
    apply(16'h0000, 64'h0, 6'h00, 16'hC040);
    act = 1'b0;
    sim = 64'h1;
    par = 1'b0;
    apply(16'h0000, 64'h0, 6'h00, 16'h4000);
    act = 1'b1;
    sim = 64'h0;
  endtask : t_state
  task t_codes;
    for (int c = 1; c < 15; c++) begin
      if (c != 6 && c != 7) apply(16'h0001 << c, 64'h0, 6'h00, 16'hA000 | (16'(c) << 8));
    end
    apply(16'h80C1, 64'h0, 6'h00, 16'h8000);
  endtask : t_codes
  task t_faults;
    apply(16'h0208, 64'h0, 6'h00, 16'hA382);
    apply(16'h0000, 64'h1 << 37, 6'h00, 16'hB625);
    apply(16'h0000, 64'h0, 6'h24, 16'hA724);
    apply(16'h0400, 64'h0, 6'h07, 16'hA784);
    apply(16'h0000, {64{1'b1}}, 6'h3F, 16'hB6BF);
  endtask : t_faults
  task t_reset;
    @(posedge clk); #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("reset word", word, 16'h0000);
    rst = 1'b0;
  endtask : t_reset
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    t_state();
    t_codes();
    t_faults();
    t_reset();
    apply(16'h0000, 64'h0, 6'h01, 16'hA701);
    results();
  end
endmodule : tb_top
`default_nettype wire
